// ==== shared/limit_bin_sorter_defines.svh ====
`ifndef LIMIT_BIN_SORTER_DEFINES_SVH
`define LIMIT_BIN_SORTER_DEFINES_SVH

// table geometry
`define NUM_PRI        9
`define NUM_RANGES     10
`define SEC_IDX        4'h9

// register byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_ENABLE    8'h04
`define ADDR_ENTRY     8'h08
`define ADDR_CMD       8'h0C
`define ADDR_STATUS    8'h10
`define ADDR_NOMINAL   8'h14
`define ADDR_LOWER_RD  8'h18
`define ADDR_UPPER_RD  8'h1C

// control register fields
`define CTRL_MODE_LSB  0
`define CTRL_MODE_MSB  1
`define CTRL_AUX_BIT   2

// command register fields
`define CMD_IDX_LSB    0
`define CMD_IDX_MSB    3
`define CMD_FLD_BIT    4
`define CMD_OP_LSB     5
`define CMD_OP_MSB     7
`define CMD_MULT_LSB   8
`define CMD_MULT_MSB   10

// status register fields
`define STAT_WARN_BIT  0
`define STAT_CAT_LSB   4
`define STAT_CAT_MSB   7

// multiplier codes and factors, values kept in pico units
`define MULT_PICO      3'h0
`define MULT_NANO      3'h1
`define MULT_MICRO     3'h2
`define MULT_MILLI     3'h3
`define FACTOR_PICO    64'h0000000000000001
`define FACTOR_NANO    64'h00000000000003E8
`define FACTOR_MICRO   64'h00000000000F4240
`define FACTOR_MILLI   64'h000000003B9ACA00
`define FACTOR_UNITY   64'h000000E8D4A51000
// one hundred percent in pico-percent
`define PCT_FULL       64'h00005AF3107A4000

// result categories
`define CAT_NONE       4'h0
`define CAT_FIRST      4'h1
`define CAT_NO_MATCH   4'hA
`define CAT_AUX        4'hB

// reset values
`define RST_WORD       32'h00000000

`endif

// ==== shared/limit_bin_sorter_pkg.sv ====
package limit_bin_sorter_pkg;

  // how primary bounds are read
  typedef enum logic [1:0] {
    absolute_mode,
    absolute_deviation_mode,
    percent_deviation_mode
  } bound_mode_t;

  // edit operations carried by the command register
  typedef enum logic [2:0] {
    op_load,
    op_clear_field,
    op_clear_line,
    op_mirror,
    op_load_nominal
  } cmd_op_t;

endpackage : limit_bin_sorter_pkg

// ==== shared/limit_cmp_if.sv ====
`timescale 1ns/10ps
interface limit_cmp_if
  import limit_bin_sorter_pkg::*;
#(
  parameter int VAL_W = 64
);
  logic signed [VAL_W-1:0] meas;
  logic signed [VAL_W-1:0] lower;
  logic signed [VAL_W-1:0] upper;
  logic signed [VAL_W-1:0] nominal;
  bound_mode_t             mode;
  logic                    enable;
  logic                    hit;
  logic                    valid;
  logic                    improper;

  modport table_side (output meas, lower, upper, nominal, mode, enable,
                      input hit, valid, improper);
  modport cmp_side   (input meas, lower, upper, nominal, mode, enable,
                      output hit, valid, improper);
endinterface : limit_cmp_if

// ==== src/limit_bin_sorter.sv ====
// Contract
// - inverted or empty range acts as switched off
// - overlapping ranges pick the lowest number
// - nominal may lie outside any range
// - gaps and any range order allowed
// - lower above upper raises improper warning
// - nine primary ranges, each field settable
// - deviation modes add nominal-based offsets
// - one separate secondary range with enable
// - clear line zeroes bounds, disables range
// - field clear touches only that bound
// - mirror loads the negated opposite bound
// - entries scaled pico to unity before storing
// - three bound modes for primary ranges
// - secondary range always absolute bounds
// - secondary miss gives auxiliary or no match
// - result is one of eleven categories
`timescale 1ns/10ps
`include "limit_bin_sorter_defines.svh"
module limit_bin_sorter
  import limit_bin_sorter_pkg::*;
#(
  parameter int VAL_W = 64
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rstn,
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  input  wire logic                    i_meas_valid,
  input  wire logic signed [VAL_W-1:0] i_meas_pri,
  input  wire logic signed [VAL_W-1:0] i_meas_sec,
  output logic                         o_result_valid,
  output logic      [3:0]              o_category,
  output logic                         o_improper_warn
);

  // refuse widths that cannot hold a unity-scaled entry
  if (VAL_W < 48 || VAL_W > 128) begin : g_width_check
    $error("limit_bin_sorter: VAL_W must lie in 48..128");
  end

  // range table, index 0..8 primary, 9 secondary
  logic signed [VAL_W-1:0] lower_reg [0:`NUM_RANGES-1];
  logic signed [VAL_W-1:0] upper_reg [0:`NUM_RANGES-1];
  logic [`NUM_RANGES-1:0]  enable_reg;
  bound_mode_t             mode_reg;
  logic                    aux_reg;
  logic signed [VAL_W-1:0] nominal_value_reg;
  logic signed [31:0]      entry_reg;
  logic [3:0]              sel_reg;
  logic                    warn_next;

  // command decode
  logic                    cmd_wr;
  logic [3:0]              cmd_idx;
  logic                    cmd_upper;
  cmd_op_t                 cmd_op;
  logic                    idx_ok;
  logic signed [VAL_W-1:0] scaled;

  // comparator results
  logic [`NUM_RANGES-1:0]  hit_vec;
  logic [`NUM_RANGES-1:0]  valid_vec;
  logic [`NUM_RANGES-1:0]  improper_vec;
  logic                    sec_fail;
  logic [3:0]              pri_cat;
  logic [3:0]              final_cat;

  // entry scaling by the selected multiplier
  function automatic logic signed [VAL_W-1:0] scale(
    input logic signed [31:0] mant,
    input logic [2:0]         mult
  );
    logic signed [VAL_W-1:0] f;
    unique case (mult)
      `MULT_PICO:  f = VAL_W'(`FACTOR_PICO);
      `MULT_NANO:  f = VAL_W'(`FACTOR_NANO);
      `MULT_MICRO: f = VAL_W'(`FACTOR_MICRO);
      `MULT_MILLI: f = VAL_W'(`FACTOR_MILLI);
      default:     f = VAL_W'(`FACTOR_UNITY);
    endcase
    return VAL_W'(mant) * f;
  endfunction : scale

  // lowest numbered matching primary range
  function automatic logic [3:0] first_hit(input logic [`NUM_PRI-1:0] h);
    logic [3:0] c;
    c = `CAT_NO_MATCH;
    for (int i = `NUM_PRI - 1; i >= 0; i--) begin
      if (h[i]) begin
        c = 4'(i + 1);
      end
    end
    return c;
  endfunction : first_hit

  // command field extraction
  assign cmd_wr    = i_wr && (i_addr == `ADDR_CMD);
  assign cmd_idx   = i_wdata[`CMD_IDX_MSB:`CMD_IDX_LSB];
  assign cmd_upper = i_wdata[`CMD_FLD_BIT];
  assign cmd_op    = cmd_op_t'(i_wdata[`CMD_OP_MSB:`CMD_OP_LSB]);
  assign idx_ok    = cmd_idx <= `SEC_IDX;
  assign scaled    = scale(entry_reg, i_wdata[`CMD_MULT_MSB:`CMD_MULT_LSB]);

  // entry mantissa and last selected range
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      entry_reg <= `RST_WORD;
      sel_reg   <= 4'h0;
    end else begin
      if (i_wr && i_addr == `ADDR_ENTRY) begin
        entry_reg <= i_wdata;
      end
      if (cmd_wr && idx_ok) begin
        sel_reg <= cmd_idx;
      end
    end
  end

  // bound fields; no ordering check between ranges, gaps allowed
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < `NUM_RANGES; i++) begin
        lower_reg[i] <= '0;
        upper_reg[i] <= '0;
      end
    end else if (cmd_wr && idx_ok) begin
      unique case (cmd_op)
        op_load: begin
          if (cmd_upper) begin
            upper_reg[cmd_idx] <= scaled;
          end else begin
            lower_reg[cmd_idx] <= scaled;
          end
        end
        op_clear_field: begin
          if (cmd_upper) begin
            upper_reg[cmd_idx] <= '0;
          end else begin
            lower_reg[cmd_idx] <= '0;
          end
        end
        op_clear_line: begin
          lower_reg[cmd_idx] <= '0;
          upper_reg[cmd_idx] <= '0;
        end
        op_mirror: begin
          // mirror_upper_to_lower on the lower field, mirror_lower_to_upper on the upper
          if (cmd_upper) begin
            upper_reg[cmd_idx] <= -lower_reg[cmd_idx];
          end else begin
            lower_reg[cmd_idx] <= -upper_reg[cmd_idx];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // enables: direct write, or dropped by a clear line
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      enable_reg <= '0;
    end else if (i_wr && i_addr == `ADDR_ENABLE) begin
      enable_reg <= i_wdata[`NUM_RANGES-1:0];
    end else if (cmd_wr && idx_ok && cmd_op == op_clear_line) begin
      enable_reg[cmd_idx] <= 1'b0;
    end
  end

  // mode, auxiliary switch and nominal value
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg          <= absolute_mode;
      aux_reg           <= 1'b0;
      nominal_value_reg <= '0;
    end else begin
      if (i_wr && i_addr == `ADDR_CTRL) begin
        mode_reg <= bound_mode_t'(i_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
        aux_reg  <= i_wdata[`CTRL_AUX_BIT];
      end
      if (cmd_wr && cmd_op == op_load_nominal) begin
        nominal_value_reg <= scaled; // no check against any range
      end
    end
  end

  // comparator per range
  limit_cmp_if #(.VAL_W(VAL_W)) cmp_bus [0:`NUM_RANGES-1] ();

  for (genvar g = 0; g < `NUM_RANGES; g++) begin : g_range
    localparam bit IS_SEC = (g == `NUM_RANGES - 1);
    assign cmp_bus[g].meas    = IS_SEC ? i_meas_sec : i_meas_pri;
    assign cmp_bus[g].lower   = lower_reg[g];
    assign cmp_bus[g].upper   = upper_reg[g];
    assign cmp_bus[g].nominal = nominal_value_reg;
    assign cmp_bus[g].mode    = IS_SEC ? absolute_mode : mode_reg;
    assign cmp_bus[g].enable  = IS_SEC ? 1'b1 : enable_reg[g];
    assign hit_vec[g]         = cmp_bus[g].hit;
    assign valid_vec[g]       = cmp_bus[g].valid;
    assign improper_vec[g]    = cmp_bus[g].improper;

    range_compare #(.VAL_W(VAL_W)) u_cmp (
      .bus (cmp_bus[g])
    );
  end

  // category selection
  always_comb begin
    pri_cat   = first_hit(hit_vec[`NUM_PRI-1:0]);
    sec_fail  = enable_reg[`NUM_RANGES-1] && valid_vec[`NUM_RANGES-1]
                && !hit_vec[`NUM_RANGES-1];
    final_cat = pri_cat;
    if (sec_fail) begin
      if (pri_cat != `CAT_NO_MATCH && aux_reg) begin
        final_cat = `CAT_AUX;
      end else begin
        final_cat = `CAT_NO_MATCH;
      end
    end
  end

  // result register, one cycle after the measurement strobe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_result_valid <= 1'b0;
      o_category     <= `CAT_NONE;
    end else begin
      o_result_valid <= i_meas_valid;
      if (i_meas_valid) begin
        o_category <= final_cat;
      end
    end
  end

  // sticky improper warning, a fresh set beats a clear
  assign warn_next = (|improper_vec)
                     || (o_improper_warn
                         && !(i_wr && i_addr == `ADDR_STATUS && i_wdata[`STAT_WARN_BIT]));

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_improper_warn <= 1'b0;
    end else begin
      o_improper_warn <= warn_next;
    end
  end

  // read data stand for exactly one cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= `RST_WORD;
    end else if (i_rd) begin
      unique case (i_addr)
        `ADDR_CTRL:     o_rdata <= {29'h0, aux_reg, mode_reg};
        `ADDR_ENABLE:   o_rdata <= {22'h0, enable_reg};
        `ADDR_ENTRY:    o_rdata <= entry_reg;
        `ADDR_CMD:      o_rdata <= {28'h0, sel_reg};
        `ADDR_STATUS:   o_rdata <= {24'h0, o_category, 3'h0, o_improper_warn};
        `ADDR_NOMINAL:  o_rdata <= nominal_value_reg[31:0];
        `ADDR_LOWER_RD: o_rdata <= lower_reg[sel_reg][31:0];
        `ADDR_UPPER_RD: o_rdata <= upper_reg[sel_reg][31:0];
        default:        o_rdata <= `RST_WORD;
      endcase
    end else begin
      o_rdata <= `RST_WORD;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  a_invalid_ignored: assert property (
    i_meas_valid && !valid_vec[0] && !sec_fail |=> o_category != `CAT_FIRST)
    else $error("inverted first range still matched");

  a_lowest_wins: assert property (
    i_meas_valid && hit_vec[0] && !sec_fail |=> o_category == `CAT_FIRST)
    else $error("first range hit not chosen");

  a_nominal_load: assert property (
    cmd_wr && cmd_op == op_load_nominal |=> nominal_value_reg == $past(scaled))
    else $error("nominal value not stored");

  a_warn_raise: assert property (
    |improper_vec |=> o_improper_warn)
    else $error("improper limits not flagged");

  a_clear_line: assert property (
    cmd_wr && idx_ok && cmd_op == op_clear_line
    |=> lower_reg[$past(cmd_idx)] == '0 && upper_reg[$past(cmd_idx)] == '0
        && !enable_reg[$past(cmd_idx)])
    else $error("clear line incomplete");

  a_field_clear: assert property (
    cmd_wr && idx_ok && cmd_op == op_clear_field && !cmd_upper
    |=> lower_reg[$past(cmd_idx)] == '0
        && upper_reg[$past(cmd_idx)] == $past(upper_reg[cmd_idx])
        && enable_reg == $past(enable_reg))
    else $error("field clear touched other state");

  a_mirror_lower: assert property (
    cmd_wr && idx_ok && cmd_op == op_mirror && !cmd_upper
    |=> lower_reg[$past(cmd_idx)] == -$past(upper_reg[cmd_idx]))
    else $error("mirror did not negate upper bound");

  a_load_scaled: assert property (
    cmd_wr && idx_ok && cmd_op == op_load && cmd_upper
    |=> upper_reg[$past(cmd_idx)] == $past(scaled))
    else $error("scaled entry not stored");

  a_aux_pick: assert property (
    i_meas_valid && pri_cat != `CAT_NO_MATCH && sec_fail && aux_reg
    |=> o_category == `CAT_AUX ##1 1'b1)
    else $error("auxiliary category missed");

  a_category_set: assert property (
    o_result_valid |-> o_category >= `CAT_FIRST && o_category <= `CAT_AUX)
    else $error("category out of set");

  a_no_match: assert property (
    i_meas_valid && hit_vec[`NUM_PRI-1:0] == '0 |=> o_category == `CAT_NO_MATCH)
    else $error("unmatched value not rejected");

  c_aux_result: cover property (
    i_meas_valid && final_cat == `CAT_AUX ##1 o_result_valid);
  c_overlap: cover property (
    i_meas_valid && hit_vec[0] && hit_vec[1]);
  c_clear_line: cover property (
    cmd_wr && cmd_op == op_clear_line);
  c_warn_clear: cover property (
    o_improper_warn ##1 !o_improper_warn);

endmodule : limit_bin_sorter

// ==== src/range_compare.sv ====
`timescale 1ns/10ps
`include "limit_bin_sorter_defines.svh"
module range_compare
  import limit_bin_sorter_pkg::*;
#(
  parameter int VAL_W = 64
) (
  limit_cmp_if.cmp_side bus
);

  localparam logic signed [2*VAL_W-1:0] PCT_FULL_W = (2*VAL_W)'(`PCT_FULL);

  logic signed [VAL_W-1:0] lo_eff;
  logic signed [VAL_W-1:0] hi_eff;

  // turn a stored field into an absolute bound
  function automatic logic signed [VAL_W-1:0] effective(
    input logic signed [VAL_W-1:0] dev,
    input bound_mode_t             md,
    input logic signed [VAL_W-1:0] nominal_value
  );
    logic signed [2*VAL_W-1:0] prod;
    prod = (2*VAL_W)'(nominal_value) * (2*VAL_W)'(dev);
    unique case (md)
      absolute_deviation_mode: return nominal_value + dev;
      percent_deviation_mode:  return nominal_value + VAL_W'(prod / PCT_FULL_W);
      default:                 return dev;
    endcase
  endfunction : effective

  // inclusive window test; an empty or inverted window never matches
  always_comb begin
    lo_eff       = effective(bus.lower, bus.mode, bus.nominal);
    hi_eff       = effective(bus.upper, bus.mode, bus.nominal);
    bus.valid    = hi_eff > lo_eff;
    bus.improper = lo_eff > hi_eff;
    bus.hit      = bus.enable && bus.valid
                   && (bus.meas >= lo_eff) && (bus.meas <= hi_eff);
  end

endmodule : range_compare

// ==== test/result_handler.sv ====
`timescale 1ns/10ps
// handler side: takes each sorting result as it is flagged and keeps a tally
module result_handler (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_result_valid,
  input  wire logic [3:0] i_category,
  output logic      [31:0] o_result_cnt,
  output logic      [3:0]  o_last_cat
);
  // latch the category only in the cycle the result is flagged
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_result_cnt <= 32'h0;
      o_last_cat   <= 4'h0;
    end else if (i_result_valid) begin
      o_result_cnt <= o_result_cnt + 32'h1;
      o_last_cat   <= i_category;
    end
  end
endmodule : result_handler

// ==== test/test_limit_bin_sorter.sv ====
`timescale 1ns/10ps
`include "limit_bin_sorter_defines.svh"
module test_limit_bin_sorter
  import limit_bin_sorter_pkg::*;
;
  logic               i_sys_clk;
  logic               i_rstn;
  logic        [7:0]  i_addr;
  logic        [31:0] i_wdata;
  logic               i_wr;
  logic               i_rd;
  logic        [31:0] o_rdata;
  logic               i_meas_valid;
  logic signed [63:0] i_meas_pri;
  logic signed [63:0] i_meas_sec;
  logic               o_result_valid;
  logic        [3:0]  o_category;
  logic               o_improper_warn;
  logic        [31:0] hcnt;
  logic        [3:0]  hcat;
  int                 error_cnt;
  int                 samples_checked;
  logic        [31:0] n_meas;
  logic        [63:0] fac [5];
  logic signed [63:0] prod;

  limit_bin_sorter dut (
    .i_sys_clk      (i_sys_clk),
    .i_rstn         (i_rstn),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .i_meas_valid   (i_meas_valid),
    .i_meas_pri     (i_meas_pri),
    .i_meas_sec     (i_meas_sec),
    .o_result_valid (o_result_valid),
    .o_category     (o_category),
    .o_improper_warn(o_improper_warn)
  );

  result_handler handler (
    .i_sys_clk     (i_sys_clk),
    .i_rstn        (i_rstn),
    .i_result_valid(o_result_valid),
    .i_category    (o_category),
    .o_result_cnt  (hcnt),
    .o_last_cat    (hcat)
  );

  // free-running system clock
  always #2.5 i_sys_clk = ~i_sys_clk;

  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    chk("rdata", exp, o_rdata);
    // read data must drop back to zero after their single cycle
    @(posedge i_sys_clk);
    #1;
    chk("rdata_idle", 32'h0, o_rdata);
  endtask : rd

  function automatic logic [31:0] cmd(input logic [3:0] idx, input logic fld,
                                      input cmd_op_t op, input logic [2:0] m);
    return {21'h0, m, op, fld, idx};
  endfunction : cmd

  task automatic ld(input logic [3:0] idx, input logic fld, input logic [31:0] v,
                    input logic [2:0] m);
    wr(`ADDR_ENTRY, v);
    wr(`ADDR_CMD, cmd(idx, fld, op_load, m));
  endtask : ld

  task automatic meas(input logic signed [63:0] p, input logic signed [63:0] s,
                      input logic [3:0] exp);
    @(posedge i_sys_clk);
    i_meas_valid <= 1'b1;
    i_meas_pri   <= p;
    i_meas_sec   <= s;
    @(posedge i_sys_clk);
    i_meas_valid <= 1'b0;
    #1;
    chk("result_valid", 32'h1, {31'h0, o_result_valid});
    chk("category", {28'h0, exp}, {28'h0, o_category});
    n_meas = n_meas + 32'h1;
  endtask : meas

  // hang guard, far beyond the expected run length
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    fac = '{`FACTOR_PICO, `FACTOR_NANO, `FACTOR_MICRO, `FACTOR_MILLI, `FACTOR_UNITY};
    i_sys_clk = 1'b0;
    i_rstn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_meas_valid = 1'b0;
    i_meas_pri = 64'sh0;
    i_meas_sec = 64'sh0;
    error_cnt = 0;
    samples_checked = 0;
    n_meas = 32'h0;
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    // reset state
    rd(`ADDR_CTRL, 32'h0);
    rd(`ADDR_ENABLE, 32'h0);
    rd(`ADDR_STATUS, 32'h0);
    chk("category", 32'h0, {28'h0, o_category});
    // every multiplier on range nine, negative so the table stays proper
    for (int m = 0; m < 5; m++) begin
      ld(4'h8, 1'b0, -32'sd3, m[2:0]);
      prod = -64'sd3 * $signed(fac[m]);
      rd(`ADDR_LOWER_RD, prod[31:0]);
    end
    // absolute table with overlap, gap and an empty range
    ld(4'h0, 1'b1, 32'd200, `MULT_PICO);
    ld(4'h0, 1'b0, 32'd100, `MULT_PICO);
    ld(4'h1, 1'b1, 32'd300, `MULT_PICO);
    ld(4'h1, 1'b0, 32'd150, `MULT_PICO);
    ld(4'h2, 1'b1, 32'd500, `MULT_PICO);
    ld(4'h2, 1'b0, 32'd400, `MULT_PICO);
    ld(4'h3, 1'b1, 32'd600, `MULT_PICO);
    ld(4'h3, 1'b0, 32'd600, `MULT_PICO);
    wr(`ADDR_ENABLE, 32'h00F);
    meas(64'sd160, 64'sd0, 4'h1);
    meas(64'sd250, 64'sd0, 4'h2);
    meas(64'sd350, 64'sd0, `CAT_NO_MATCH);
    meas(64'sd400, 64'sd0, 4'h3);
    meas(64'sd500, 64'sd0, 4'h3);
    meas(64'sd99, 64'sd0, `CAT_NO_MATCH);
    meas(64'sd600, 64'sd0, `CAT_NO_MATCH);
    chk("warn", 32'h0, {31'h0, o_improper_warn});
    // inverted range five
    ld(4'h4, 1'b1, 32'd700, `MULT_PICO);
    ld(4'h4, 1'b0, 32'd800, `MULT_PICO);
    wr(`ADDR_ENABLE, 32'h01F);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("warn", 32'h1, {31'h0, o_improper_warn});
    meas(64'sd750, 64'sd0, `CAT_NO_MATCH);
    wr(`ADDR_CMD, cmd(4'h4, 1'b0, op_clear_line, `MULT_PICO));
    rd(`ADDR_ENABLE, 32'h00F);
    rd(`ADDR_LOWER_RD, 32'h0);
    rd(`ADDR_UPPER_RD, 32'h0);
    // single field clear on range one
    wr(`ADDR_CMD, cmd(4'h0, 1'b1, op_clear_field, `MULT_PICO));
    rd(`ADDR_UPPER_RD, 32'h0);
    rd(`ADDR_LOWER_RD, 32'd100);
    rd(`ADDR_ENABLE, 32'h00F);
    ld(4'h0, 1'b1, 32'd200, `MULT_PICO);
    wr(`ADDR_STATUS, 32'h1);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("warn", 32'h0, {31'h0, o_improper_warn});
    // mirror both ways
    ld(4'h5, 1'b1, 32'd50, `MULT_PICO);
    wr(`ADDR_CMD, cmd(4'h5, 1'b0, op_mirror, `MULT_PICO));
    rd(`ADDR_LOWER_RD, -32'sd50);
    // lower field clear keeps the upper bound
    wr(`ADDR_CMD, cmd(4'h5, 1'b0, op_clear_field, `MULT_PICO));
    rd(`ADDR_LOWER_RD, 32'h0);
    rd(`ADDR_UPPER_RD, 32'd50);
    ld(4'h6, 1'b0, -32'sd70, `MULT_PICO);
    wr(`ADDR_CMD, cmd(4'h6, 1'b1, op_mirror, `MULT_PICO));
    rd(`ADDR_UPPER_RD, 32'd70);
    // absolute deviation around a nominal outside range seven
    ld(4'h6, 1'b1, 32'd200, `MULT_PICO);
    ld(4'h6, 1'b0, 32'd100, `MULT_PICO);
    wr(`ADDR_ENTRY, 32'd1000);
    wr(`ADDR_CMD, cmd(4'h0, 1'b0, op_load_nominal, `MULT_PICO));
    rd(`ADDR_NOMINAL, 32'd1000);
    wr(`ADDR_ENABLE, 32'h060);
    meas(64'sd0, 64'sd0, 4'h6);
    wr(`ADDR_CTRL, 32'h1);
    meas(64'sd1040, 64'sd0, 4'h6);
    meas(64'sd1060, 64'sd0, `CAT_NO_MATCH);
    meas(64'sd0, 64'sd0, `CAT_NO_MATCH);
    meas(64'sd1150, 64'sd0, 4'h7);
    // percent deviation with a secondary range
    ld(4'h7, 1'b1, 32'd1, 3'h4);
    ld(4'h7, 1'b0, -32'sd2, 3'h4);
    ld(4'h9, 1'b1, 32'd20, `MULT_PICO);
    ld(4'h9, 1'b0, 32'd10, `MULT_PICO);
    wr(`ADDR_ENTRY, 32'd1000000);
    wr(`ADDR_CMD, cmd(4'h9, 1'b0, op_load_nominal, `MULT_PICO));
    wr(`ADDR_CTRL, 32'h2);
    wr(`ADDR_ENABLE, 32'h280);
    meas(64'sd979999, 64'sd15, `CAT_NO_MATCH);
    meas(64'sd980000, 64'sd15, 4'h8);
    meas(64'sd1010000, 64'sd15, 4'h8);
    meas(64'sd1010001, 64'sd15, `CAT_NO_MATCH);
    meas(64'sd1000000, 64'sd25, `CAT_NO_MATCH);
    wr(`ADDR_CTRL, 32'h6);
    meas(64'sd1000000, 64'sd25, `CAT_AUX);
    meas(64'sd1000000, 64'sd9, `CAT_AUX);
    meas(64'sd0, 64'sd25, `CAT_NO_MATCH);
    meas(64'sd1000000, 64'sd20, 4'h8);
    wr(`ADDR_ENABLE, 32'h080);
    meas(64'sd1000000, 64'sd25, 4'h8);
    // refused command index and unmapped address
    wr(`ADDR_CMD, cmd(4'hA, 1'b0, op_clear_line, `MULT_PICO));
    rd(`ADDR_CMD, 32'h9);
    rd(`ADDR_ENABLE, 32'h080);
    rd(8'h20, 32'h0);
    // unused op code on range eight leaves its bounds alone
    wr(`ADDR_CMD, 32'h000000A7);
    prod = -64'sd2 * $signed(fac[4]);
    rd(`ADDR_LOWER_RD, prod[31:0]);
    // mode code three reads bounds as absolute values
    wr(`ADDR_CTRL, 32'h3);
    meas(64'sd1000000000001, 64'sd0, `CAT_NO_MATCH);
    meas(64'sd0, 64'sd0, 4'h8);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("handler_count", n_meas, hcnt);
    chk("handler_cat", 32'h8, {28'h0, hcat});
    end_of_test();
  end
endmodule : test_limit_bin_sorter
